// file: flash_read_pkg.sv
// Constants, opcodes, register map and carrier types of the serial flash read core
package flash_read_pkg;

  // ==========================================================
  // Link carriers
  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic [3:0] io;
  } link_in_type;

  typedef struct packed {
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } link_out_type;

  // ==========================================================
  // States, protocols, decoded command
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_OPCODE   = 3'b001,
    ST_ADDR     = 3'b010,
    ST_DUMMY    = 3'b011,
    ST_DATA     = 3'b100,
    ST_WAIT_END = 3'b101,
    ST_IGNORE   = 3'b110
  } link_state_type;

  typedef enum logic [1:0] {
    PROTO_EXT  = 2'b00,
    PROTO_DUAL = 2'b01,
    PROTO_QUAD = 2'b10
  } protocol_type;

  typedef struct packed {
    logic       valid;
    logic       is_read;
    logic       set_wel;
    logic       clr_wel;
    logic [1:0] addr_lg;
    logic [1:0] data_lg;
    logic       dtr;
    logic       force_addr4;
    logic       no_dummy;
  } cmd_type;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_READ3      = 8'h03;
  localparam logic [7:0] OP_READ4      = 8'h13;
  localparam logic [7:0] OP_FAST3      = 8'h0B;
  localparam logic [7:0] OP_FAST4      = 8'h0C;
  localparam logic [7:0] OP_DOUT3      = 8'h3B;
  localparam logic [7:0] OP_DOUT4      = 8'h3C;
  localparam logic [7:0] OP_DIO3       = 8'hBB;
  localparam logic [7:0] OP_DIO4       = 8'hBC;
  localparam logic [7:0] OP_QOUT3      = 8'h6B;
  localparam logic [7:0] OP_QOUT4      = 8'h6C;
  localparam logic [7:0] OP_QIO3       = 8'hEB;
  localparam logic [7:0] OP_QIO4       = 8'hEC;
  localparam logic [7:0] OP_QWORD      = 8'hE7;
  localparam logic [7:0] OP_DTR_FAST3  = 8'h0D;
  localparam logic [7:0] OP_DTR_FAST4  = 8'h0E;
  localparam logic [7:0] OP_DTR_DOUT   = 8'h3D;
  localparam logic [7:0] OP_DTR_DIO3   = 8'hBD;
  localparam logic [7:0] OP_DTR_DIO4   = 8'hBE;
  localparam logic [7:0] OP_DTR_QOUT   = 8'h6D;
  localparam logic [7:0] OP_DTR_QIO3   = 8'hED;
  localparam logic [7:0] OP_DTR_QIO4   = 8'hEE;
  localparam logic [7:0] OP_WRITE_EN   = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS  = 8'h04;

  // ==========================================================
  // Register map and fields
  localparam logic [4:0]  OFS_CONFIG    = 5'h00;
  localparam logic [4:0]  OFS_STATUS    = 5'h04;
  localparam logic [4:0]  OFS_CONTROL   = 5'h08;
  localparam logic [4:0]  OFS_MEM_ADDR  = 5'h0C;
  localparam logic [4:0]  OFS_MEM_DATA  = 5'h10;
  localparam int          CFG_PROTO_LSB = 0;
  localparam int          CFG_DTR_BIT   = 2;
  localparam int          CFG_NV_A4_BIT = 3;
  localparam int          CFG_VOL_A4_BIT = 4;
  localparam int          CFG_DUMMY_LSB = 8;
  localparam logic [31:0] CFG_MASK      = 32'h0000_0F1F;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0800;
  localparam int          CTL_CLEAR_BIT = 0;
  localparam int          CTL_PROT_BIT  = 1;
  localparam logic [5:0]  OPCODE_BITS   = 6'h08;
  localparam logic [5:0]  ADDR3_BITS    = 6'h18;
  localparam logic [5:0]  ADDR4_BITS    = 6'h20;

endpackage

// file: flash_read_core.sv
// Device-side read and write-latch command interpreter of a serial NOR flash
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps

module flash_read_core #(
  parameter int MEM_AW = 10
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic [4:0]                  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  input  wire logic [3:0]                  byteenable,
  output logic [31:0]                      readdata,
  output logic                             waitrequest,
  input  wire flash_read_pkg::link_in_type  link_in,
  output flash_read_pkg::link_out_type     link_out
);
  import flash_read_pkg::*;

  // ==========================================================
  // Helpers
  function automatic cmd_type decode(input logic [7:0] op, input protocol_type proto);
    cmd_type    c;
    logic       ed;
    logic       eq;
    logic [1:0] plg;
    c   = '0;
    ed  = (proto != PROTO_QUAD);
    eq  = (proto != PROTO_DUAL);
    plg = (proto == PROTO_QUAD) ? 2'd2 : (proto == PROTO_DUAL) ? 2'd1 : 2'd0;
    case (op)
      OP_READ3:     c = '{1'b1, 1'b1, 1'b0, 1'b0, 2'd0, 2'd0, 1'b0, 1'b0, 1'b1};
      OP_READ4:     c = '{1'b1, 1'b1, 1'b0, 1'b0, 2'd0, 2'd0, 1'b0, 1'b1, 1'b1};
      OP_FAST3:     c = '{1'b1, 1'b1, 1'b0, 1'b0, 2'd0, 2'd0, 1'b0, 1'b0, 1'b0};
      OP_FAST4:     c = '{1'b1, 1'b1, 1'b0, 1'b0, 2'd0, 2'd0, 1'b0, 1'b1, 1'b0};
      OP_DOUT3:     c = '{ed, 1'b1, 1'b0, 1'b0, 2'd0, 2'd1, 1'b0, 1'b0, 1'b0};
      OP_DOUT4:     c = '{ed, 1'b1, 1'b0, 1'b0, 2'd0, 2'd1, 1'b0, 1'b1, 1'b0};
      OP_DIO3:      c = '{ed, 1'b1, 1'b0, 1'b0, 2'd1, 2'd1, 1'b0, 1'b0, 1'b0};
      OP_DIO4:      c = '{ed, 1'b1, 1'b0, 1'b0, 2'd1, 2'd1, 1'b0, 1'b1, 1'b0};
      OP_QOUT3:     c = '{eq, 1'b1, 1'b0, 1'b0, 2'd0, 2'd2, 1'b0, 1'b0, 1'b0};
      OP_QOUT4:     c = '{eq, 1'b1, 1'b0, 1'b0, 2'd0, 2'd2, 1'b0, 1'b1, 1'b0};
      OP_QIO3:      c = '{eq, 1'b1, 1'b0, 1'b0, 2'd2, 2'd2, 1'b0, 1'b0, 1'b0};
      OP_QIO4:      c = '{eq, 1'b1, 1'b0, 1'b0, 2'd2, 2'd2, 1'b0, 1'b1, 1'b0};
      OP_QWORD:     c = '{eq, 1'b1, 1'b0, 1'b0, 2'd2, 2'd2, 1'b0, 1'b0, 1'b0};
      OP_DTR_FAST3: c = '{1'b1, 1'b1, 1'b0, 1'b0, 2'd0, 2'd0, 1'b1, 1'b0, 1'b0};
      OP_DTR_FAST4: c = '{1'b1, 1'b1, 1'b0, 1'b0, 2'd0, 2'd0, 1'b1, 1'b1, 1'b0};
      OP_DTR_DOUT:  c = '{ed, 1'b1, 1'b0, 1'b0, 2'd0, 2'd1, 1'b1, 1'b0, 1'b0};
      OP_DTR_DIO3:  c = '{ed, 1'b1, 1'b0, 1'b0, 2'd1, 2'd1, 1'b1, 1'b0, 1'b0};
      OP_DTR_DIO4:  c = '{ed, 1'b1, 1'b0, 1'b0, 2'd1, 2'd1, 1'b1, 1'b1, 1'b0};
      OP_DTR_QOUT:  c = '{eq, 1'b1, 1'b0, 1'b0, 2'd0, 2'd2, 1'b1, 1'b0, 1'b0};
      OP_DTR_QIO3:  c = '{eq, 1'b1, 1'b0, 1'b0, 2'd2, 2'd2, 1'b1, 1'b0, 1'b0};
      OP_DTR_QIO4:  c = '{eq, 1'b1, 1'b0, 1'b0, 2'd2, 2'd2, 1'b1, 1'b1, 1'b0};
      OP_WRITE_EN:  c = '{1'b1, 1'b0, 1'b1, 1'b0, 2'd0, 2'd0, 1'b0, 1'b0, 1'b0};
      OP_WRITE_DIS: c = '{1'b1, 1'b0, 1'b0, 1'b1, 2'd0, 2'd0, 1'b0, 1'b0, 1'b0};
      default:      c = '0;
    endcase
    // Protocol line count is a floor for both phases
    if (c.addr_lg < plg)
      c.addr_lg = plg;
    if (c.data_lg < plg)
      c.data_lg = plg;
    return c;
  endfunction

  function automatic logic [5:0] lines_of(input logic [1:0] lg);
    return (lg == 2'd2) ? 6'd4 : (lg == 2'd1) ? 6'd2 : 6'd1;
  endfunction

  function automatic logic [31:0] shift_in(input logic [31:0] v, input logic [3:0] io, input logic [1:0] lg);
    return (lg == 2'd2) ? {v[27:0], io} : (lg == 2'd1) ? {v[29:0], io[1:0]} : {v[30:0], io[0]};
  endfunction

  function automatic logic [3:0] place(input logic [7:0] b, input logic [1:0] lg);
    return (lg == 2'd2) ? b[7:4] : (lg == 2'd1) ? {2'b00, b[7:6]} : {2'b00, b[7], 1'b0};
  endfunction

  // ==========================================================
  // Link input synchronisers
  logic                 sclk_s1_q;
  logic                 sclk_s2_q;
  logic                 sclk_s3_q;
  logic                 cs_s1_q;
  logic                 cs_s2_q;
  logic [3:0]           io_s1_q;
  logic [3:0]           io_s2_q;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      io_s1_q   <= 4'h0;
      io_s2_q   <= 4'h0;
    end
    else
    begin
      sclk_s1_q <= link_in.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q   <= link_in.cs_n;
      cs_s2_q   <= cs_s1_q;
      io_s1_q   <= link_in.io;
      io_s2_q   <= io_s1_q;
    end
  end

  // ==========================================================
  // State and registers
  link_state_type       state_q;
  link_state_type       state_d;
  cmd_type              cmd_q;
  cmd_type              cmd_d;
  logic [7:0]           op_q;
  logic [7:0]           op_d;
  logic [5:0]           bit_cnt_q;
  logic [5:0]           bit_cnt_d;
  logic [31:0]          shift_q;
  logic [31:0]          shift_d;
  logic                 dtr_q;
  logic                 dtr_d;
  logic                 addr4_q;
  logic                 addr4_d;
  logic [3:0]           dummy_q;
  logic [3:0]           dummy_d;
  logic [3:0]           dummy_cnt_q;
  logic [3:0]           dummy_cnt_d;
  logic [31:0]          rd_addr_q;
  logic [31:0]          rd_addr_d;
  logic [7:0]           out_byte_q;
  logic [7:0]           out_byte_d;
  logic [3:0]           out_left_q;
  logic [3:0]           out_left_d;
  link_out_type         link_out_q;
  link_out_type         link_out_d;
  logic                 wel_q;
  logic                 wel_d;
  logic                 prot_err_q;
  logic                 prot_err_d;
  logic [31:0]          cfg_q;
  logic [MEM_AW-1:0]    mem_addr_q;
  logic [7:0]           mem_q [2**MEM_AW];
  logic                 waitrequest_q;
  logic [31:0]          readdata_q;

  // ==========================================================
  // Decoding wires
  wire logic            sclk_rise   = sclk_s2_q & ~sclk_s3_q;
  wire logic            sclk_fall   = ~sclk_s2_q & sclk_s3_q;
  wire logic            deselect    = cs_s2_q;
  wire protocol_type    proto       = protocol_type'(cfg_q[CFG_PROTO_LSB +: 2]);
  wire logic            addr4_eff   = cfg_q[CFG_NV_A4_BIT] | cfg_q[CFG_VOL_A4_BIT];
  wire logic [5:0]      op_step     = lines_of(2'(proto));
  wire logic [7:0]      op_next     = 8'(shift_in({24'h0, op_q}, io_s2_q, 2'(proto)));
  wire logic [5:0]      op_cnt_next = bit_cnt_q + op_step;
  wire cmd_type         cmd_new     = decode(op_next, proto);
  // First double-rate address bit needs a rising edge, else the opcode's last fall counts
  wire logic            addr_evt    = sclk_rise | (dtr_q & sclk_fall & (bit_cnt_q != 6'h00));
  wire logic [5:0]      addr_step   = lines_of(cmd_q.addr_lg);
  wire logic [5:0]      addr_cnt_nx = bit_cnt_q + addr_step;
  wire logic [31:0]     addr_next   = shift_in(shift_q, io_s2_q, cmd_q.addr_lg);
  wire logic [5:0]      addr_bits   = addr4_q ? ADDR4_BITS : ADDR3_BITS;
  wire logic            out_evt     = sclk_fall | (dtr_q & sclk_rise);
  wire logic            need_byte   = (out_left_q == 4'h0);
  wire logic [7:0]      mem_byte    = mem_q[rd_addr_q[MEM_AW-1:0]];
  wire logic [7:0]      cur_byte    = need_byte ? mem_byte : out_byte_q;
  wire logic [3:0]      data_step   = 4'(lines_of(cmd_q.data_lg));
  wire logic [3:0]      data_oe     = (cmd_q.data_lg == 2'd2) ? 4'hF : (cmd_q.data_lg == 2'd1) ? 4'h3 : 4'h2;
  wire logic            bus_req     = read | write;
  wire logic            bus_commit  = ~waitrequest_q;
  wire logic            wr_commit   = write & bus_commit;
  wire logic            clr_flags   = wr_commit & (address == OFS_CONTROL) & byteenable[0]
                                      & writedata[CTL_CLEAR_BIT];
  wire logic            set_prot    = wr_commit & (address == OFS_CONTROL) & byteenable[0]
                                      & writedata[CTL_PROT_BIT];
  wire logic            wel_exec    = (state_q == ST_WAIT_END) & deselect;
  wire logic [31:0]     be_mask     = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire logic [31:0]     status_word = {16'h0, op_q, 4'h0, (state_q != ST_IDLE), addr4_eff, prot_err_q, wel_q};

  // ==========================================================
  // Link sequencing
  always_comb
  begin
    state_d     = state_q;
    cmd_d       = cmd_q;
    op_d        = op_q;
    bit_cnt_d   = bit_cnt_q;
    shift_d     = shift_q;
    dtr_d       = dtr_q;
    addr4_d     = addr4_q;
    dummy_d     = dummy_q;
    dummy_cnt_d = dummy_cnt_q;
    rd_addr_d   = rd_addr_q;
    out_byte_d  = out_byte_q;
    out_left_d  = out_left_q;
    link_out_d  = link_out_q;
    if (deselect)
    begin
      state_d    = ST_IDLE;
      link_out_d = '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          state_d   = ST_OPCODE;
          op_d      = 8'h00;
          bit_cnt_d = 6'h00;
          shift_d   = 32'h0;
        end
        ST_OPCODE:
          if (sclk_rise)
          begin
            op_d      = op_next;
            bit_cnt_d = op_cnt_next;
            if (op_cnt_next == OPCODE_BITS)
            begin
              cmd_d     = cmd_new;
              bit_cnt_d = 6'h00;
              dtr_d     = cmd_new.dtr | cfg_q[CFG_DTR_BIT];
              addr4_d   = cmd_new.force_addr4 | addr4_eff;
              dummy_d   = cfg_q[CFG_DUMMY_LSB +: 4];
              if (!cmd_new.valid)
                state_d = ST_IGNORE;
              else if (cmd_new.is_read)
                state_d = ST_ADDR;
              else
                state_d = ST_WAIT_END;
            end
          end
        ST_ADDR:
          if (addr_evt)
          begin
            shift_d   = addr_next;
            bit_cnt_d = addr_cnt_nx;
            if (addr_cnt_nx == addr_bits)
            begin
              rd_addr_d   = addr_next;
              dummy_cnt_d = 4'h0;
              out_left_d  = 4'h0;
              if (cmd_q.no_dummy || dummy_q == 4'h0)
                state_d = ST_DATA;
              else
                state_d = ST_DUMMY;
            end
          end
        ST_DUMMY:
          if (sclk_rise)
          begin
            dummy_cnt_d = dummy_cnt_q + 4'h1;
            if (dummy_cnt_q + 4'h1 == dummy_q)
              state_d = ST_DATA;
          end
        ST_DATA:
          if (out_evt)
          begin
            link_out_d.io_out = place(cur_byte, cmd_q.data_lg);
            link_out_d.io_oe  = data_oe;
            out_byte_d        = 8'(cur_byte << data_step);
            out_left_d        = (need_byte ? 4'h8 : out_left_q) - data_step;
            if (need_byte)
              rd_addr_d = rd_addr_q + 32'h1;
          end
        ST_WAIT_END:
          if (sclk_rise)
            state_d = ST_IGNORE;
        ST_IGNORE:
          state_d = ST_IGNORE;
        default:
          state_d = ST_IGNORE;
      endcase
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_comb
  begin
    wel_d      = wel_q;
    prot_err_d = prot_err_q;
    if (clr_flags)
    begin
      wel_d      = 1'b0;
      prot_err_d = 1'b0;
    end
    if (set_prot)
      prot_err_d = 1'b1;
    if (wel_exec && cmd_q.clr_wel && !prot_err_q)
      wel_d = 1'b0;
    if (wel_exec && cmd_q.set_wel)
      wel_d = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_IDLE;
      cmd_q       <= '0;
      op_q        <= 8'h00;
      bit_cnt_q   <= 6'h00;
      shift_q     <= 32'h0;
      dtr_q       <= 1'b0;
      addr4_q     <= 1'b0;
      dummy_q     <= 4'h0;
      dummy_cnt_q <= 4'h0;
      rd_addr_q   <= 32'h0;
      out_byte_q  <= 8'h00;
      out_left_q  <= 4'h0;
      link_out_q  <= '0;
      wel_q       <= 1'b0;
      prot_err_q  <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      cmd_q       <= cmd_d;
      op_q        <= op_d;
      bit_cnt_q   <= bit_cnt_d;
      shift_q     <= shift_d;
      dtr_q       <= dtr_d;
      addr4_q     <= addr4_d;
      dummy_q     <= dummy_d;
      dummy_cnt_q <= dummy_cnt_d;
      rd_addr_q   <= rd_addr_d;
      out_byte_q  <= out_byte_d;
      out_left_q  <= out_left_d;
      link_out_q  <= link_out_d;
      wel_q       <= wel_d;
      prot_err_q  <= prot_err_d;
    end
  end

  // ==========================================================
  // Avalon slave, one wait state per access
  wire logic [31:0] rd_mux = (address == OFS_CONFIG)   ? cfg_q :
                             (address == OFS_STATUS)   ? status_word :
                             (address == OFS_MEM_ADDR) ? 32'(mem_addr_q) :
                             (address == OFS_MEM_DATA) ? {24'h0, mem_q[mem_addr_q]} : 32'h0;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      waitrequest_q <= 1'b1;
      readdata_q    <= 32'h0;
      cfg_q         <= CFG_RESET;
      mem_addr_q    <= '0;
    end
    else
    begin
      waitrequest_q <= ~(bus_req & waitrequest_q);
      if (bus_req && waitrequest_q)
        readdata_q <= rd_mux;
      if (wr_commit && address == OFS_CONFIG)
        cfg_q <= (cfg_q & ~(be_mask & CFG_MASK)) | (writedata & be_mask & CFG_MASK);
      if (wr_commit && address == OFS_MEM_ADDR)
        mem_addr_q <= MEM_AW'((32'(mem_addr_q) & ~be_mask) | (writedata & be_mask));
      else if (wr_commit && address == OFS_MEM_DATA && byteenable[0])
        mem_addr_q <= mem_addr_q + 1'b1;
    end
  end

  // Array left unreset: contents are data, not control
  always_ff @(posedge clock)
  begin
    if (wr_commit && address == OFS_MEM_DATA && byteenable[0])
      mem_q[mem_addr_q] <= writedata[7:0];
  end

  assign readdata    = readdata_q;
  assign waitrequest = waitrequest_q;
  assign link_out    = link_out_q;

  // ==========================================================
  // Assertions
  property p_deselect_release;
    @(posedge clock) disable iff (!rst_n)
    deselect |=> (link_out_q.io_oe == 4'h0 && state_q == ST_IDLE);
  endproperty
  a_deselect_release: assert property (p_deselect_release) else $error("Outputs not released on deselect");

  property p_wen_sets;
    @(posedge clock) disable iff (!rst_n)
    (wel_exec && cmd_q.set_wel) |=> wel_q;
  endproperty
  a_wen_sets: assert property (p_wen_sets) else $error("Write enable did not set latch");

  property p_wdis_clears;
    @(posedge clock) disable iff (!rst_n)
    (wel_exec && cmd_q.clr_wel && !prot_err_q) |=> !wel_q;
  endproperty
  a_wdis_clears: assert property (p_wdis_clears) else $error("Write disable did not clear latch");

  property p_wdis_protected;
    @(posedge clock) disable iff (!rst_n)
    (wel_exec && cmd_q.clr_wel && prot_err_q && !clr_flags && wel_q) |=> wel_q;
  endproperty
  a_wdis_protected: assert property (p_wdis_protected) else $error("Latch cleared under protection error");

  property p_late_deselect;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_WAIT_END && !deselect && sclk_rise && !clr_flags)
      |=> (state_q == ST_IGNORE && wel_q == $past(wel_q)) ##1 (state_q == ST_IGNORE || state_q == ST_IDLE);
  endproperty
  a_late_deselect: assert property (p_late_deselect) else $error("Late deselect not ignored");

  property p_addr_width;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_ADDR ##1 (state_q == ST_DUMMY || state_q == ST_DATA)) |-> bit_cnt_q == addr_bits;
  endproperty
  a_addr_width: assert property (p_addr_width) else $error("Address phase length wrong");

  property p_addr_rise_only;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_ADDR && !dtr_q && !sclk_rise && !deselect) |=> $stable(bit_cnt_q);
  endproperty
  a_addr_rise_only: assert property (p_addr_rise_only) else $error("Address sampled off rising edge");

  property p_auto_increment;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_DATA && out_evt && need_byte && !deselect) |=> rd_addr_q == $past(rd_addr_q) + 32'h1;
  endproperty
  a_auto_increment: assert property (p_auto_increment) else $error("Read address did not advance");

  property p_dummy_count;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_DUMMY ##1 state_q == ST_DATA) |-> dummy_cnt_q == dummy_q;
  endproperty
  a_dummy_count: assert property (p_dummy_count) else $error("Dummy count mismatch");

  property p_data_on_edge;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_DATA && !dtr_q && !sclk_fall && !deselect) |=> $stable(link_out_q.io_out);
  endproperty
  a_data_on_edge: assert property (p_data_on_edge) else $error("Data changed off falling edge");

  property p_forced_addr4;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_OPCODE ##1 (state_q == ST_ADDR && cmd_q.force_addr4)) |-> addr4_q;
  endproperty
  a_forced_addr4: assert property (p_forced_addr4) else $error("4-byte opcode not forced wide");

  property p_std_read_no_dummy;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_ADDR ##1 (state_q != ST_ADDR && state_q != ST_IDLE && cmd_q.no_dummy)) |-> state_q == ST_DATA;
  endproperty
  a_std_read_no_dummy: assert property (p_std_read_no_dummy) else $error("Standard read used dummies");

endmodule

// file: flash_host_model.sv
// Host-side serial link model for the flash read core
`timescale 1ns/10ps
module flash_host_model (
  output flash_read_pkg::link_in_type       lnk,
  input  wire flash_read_pkg::link_out_type lo
);
  import flash_read_pkg::*;
  // ========
  // Wire level: device wins where it drives
  logic       sclk = 1'b0;
  logic       cs_n = 1'b1;
  logic [3:0] hio  = 4'h0;
  assign lnk = {sclk, cs_n, (lo.io_oe & lo.io_out) | (~lo.io_oe & hio)};
  // Clock stands low between frames
  task automatic clk1(input logic [3:0] v, output logic [3:0] r);
    hio = v;
    #62.5 sclk = 1'b1;
    r = lnk.io;
    #62.5 sclk = 1'b0;
  endtask
  task automatic frame(input logic [39:0] v, input int nb);
    logic [3:0] r;
    cs_n = 1'b0;
    for (int i = 39; i > 39 - 8 * nb; i--)
      clk1({~v[i], ~v[i], ~v[i], v[i]}, r);
  endtask
  // Idle lines toggle so a stale level never passes
  task automatic get(output logic [7:0] d, input int n);
    logic [3:0] r;
    d = 8'h00;
    for (int i = 0; i < 8 / n; i++)
    begin
      clk1(~hio, r);
      d = (n == 4) ? {d[3:0], r} : (n == 2) ? {d[5:0], r[1:0]} : {d[6:0], r[1]};
    end
  endtask
  task automatic stop();
    #62.5 cs_n = 1'b1;
    #500;
  endtask
endmodule

// file: flash_read_core_tb.sv
// Self-checking bench for the flash read core
`timescale 1ns/10ps
module flash_read_core_tb;
  import flash_read_pkg::*;
  logic         clock     = 1'b0;
  logic         rst_n     = 1'b0;
  logic [4:0]   address   = 5'h00;
  logic         read      = 1'b0;
  logic         write     = 1'b0;
  logic [31:0]  writedata = 32'h0;
  logic [31:0]  readdata;
  logic         waitrequest;
  link_in_type  link_in;
  link_out_type link_out;
  int           fail_count = 0;
  int           n_compared = 0;
  int           cycles     = 0;
  flash_read_core #(.MEM_AW(4)) flash_read_core_inst (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .link_in(link_in), .link_out(link_out));
  flash_host_model flash_host_model_inst (.lnk(link_in), .lo(link_out));
  initial forever #5 clock = ~clock;
  // ========
  // Bus and compare tasks
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v, output logic [31:0] q);
    @(posedge clock);
    address <= a;
    writedata <= v;
    write <= w;
    read <= ~w;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rr(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask
  task automatic op(input logic [39:0] v, input logic extra);
    logic [3:0] r;
    flash_host_model_inst.frame(v, 1);
    if (extra)
      flash_host_model_inst.clk1(4'h5, r);
    flash_host_model_inst.stop();
  endtask
  // One dummy unit is one byte of clocks
  task automatic rdx(input logic [39:0] v, input int nb, input int dum, input int n, input logic [15:0] e);
    logic [7:0] d0;
    logic [7:0] d1;
    flash_host_model_inst.frame(v, nb);
    repeat (dum) flash_host_model_inst.get(d0, 1);
    flash_host_model_inst.get(d0, n);
    flash_host_model_inst.get(d1, n);
    flash_host_model_inst.stop();
    chk({16'h0, d0, d1}, {16'h0, e});
  endtask
  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ========
  // Scenarios
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rr(OFS_CONFIG, 32'hFFFFFFFF, 32'h00000800);
    rr(5'h14, 32'hFFFFFFFF, 32'h0);
    wr(OFS_MEM_ADDR, 32'h0);
    wr(OFS_MEM_DATA, 32'hA5);
    wr(OFS_MEM_DATA, 32'h3C);
    wr(OFS_MEM_DATA, 32'h96);
    wr(OFS_MEM_DATA, 32'h0F);
    op(40'h0600000000, 1'b0);
    rr(OFS_STATUS, 32'h3, 32'h1);
    op(40'h0400000000, 1'b0);
    rr(OFS_STATUS, 32'h3, 32'h0);
    op(40'h0600000000, 1'b1);
    rr(OFS_STATUS, 32'h3, 32'h0);
    wr(OFS_CONTROL, 32'h2);
    op(40'h0600000000, 1'b0);
    op(40'h0400000000, 1'b0);
    rr(OFS_STATUS, 32'h3, 32'h3);
    wr(OFS_CONTROL, 32'h1);
    rr(OFS_STATUS, 32'h3, 32'h0);
    rdx(40'h0300000000, 4, 0, 1, 16'hA53C);
    chk({28'h0, link_out.io_oe}, 32'h0);
    rr(OFS_STATUS, 32'h8, 32'h0);
    rdx(40'h1300000001, 5, 0, 1, 16'h3C96);
    rdx(40'h0B00000100, 4, 1, 1, 16'h3C96);
    rdx(40'h3B00000100, 4, 1, 2, 16'h3C96);
    rdx(40'h6B00000200, 4, 1, 4, 16'h960F);
    wr(OFS_CONFIG, 32'h00000810);
    rr(OFS_STATUS, 32'h4, 32'h4);
    rdx(40'h0300000002, 5, 0, 1, 16'h960F);
    finish_test();
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fail_count++;
      finish_test();
    end
  end
endmodule
